// File: merc_regs.vh
// Register map, field layout, range limits and timing constants of the event record bank.
// How it works
// R1: Selection 1 shows oldest unread record; selection 2 shows oldest stored record.
// R2: Selection 3 empties the event buffer and drops every stored record.
// R3: Negative selection -n shows the n-th newest stored record.
// R4: Selection register reads back and accepts writes; other record registers are read-only.
// R5: Date packs year.month in one word and day.hour in the next.
// R6: Time packs minute.second in one word, then milliseconds 0 to 999.
// R7: Type register MSB clear marks a digital input event; low bits give point.
// R8: Type register MSB set marks an informative event; low bits give channel.
// R9: Digital input event value register holds the input level, zero or one.
// R10: Informative event value register holds the station bus code, 0 to 63.
// R11: Running clock is readable as seven contiguous registers, year to hundredths.
// R12: Clock loads only after all seven registers are preset in one transaction.
// R13: Every clock field stays inside its range, day limited by month length.
// R14: Status flag is high while unread records remain stored.
// R15: Presenting the oldest unread record decrements unread count and advances sequence, 255 wraps to 1.
`ifndef MERC_REGS_VH
`define MERC_REGS_VH

// Register word addresses.
`define MERC_ADDR_SELECT 16'h029f
`define MERC_ADDR_SEQUENCE 16'h02a0
`define MERC_ADDR_UNREAD 16'h02a1
`define MERC_ADDR_YEAR_MONTH 16'h02a2
`define MERC_ADDR_DAY_HOUR 16'h02a3
`define MERC_ADDR_MIN_SEC 16'h02a4
`define MERC_ADDR_MSEC 16'h02a5
`define MERC_ADDR_TYPE 16'h02a6
`define MERC_ADDR_VALUE 16'h02a7
`define MERC_ADDR_CLK_YEAR 16'h02d1
`define MERC_ADDR_CLK_MONTH 16'h02d2
`define MERC_ADDR_CLK_DAY 16'h02d3
`define MERC_ADDR_CLK_HOUR 16'h02d4
`define MERC_ADDR_CLK_MINUTE 16'h02d5
`define MERC_ADDR_CLK_SECOND 16'h02d6
`define MERC_ADDR_CLK_HUNDREDTHS 16'h02d7

// Selection codes.
`define MERC_SEL_OLDEST_UNREAD 16'h0001
`define MERC_SEL_OLDEST_STORED 16'h0002
`define MERC_SEL_CLEAR 16'h0003

// Record store limits.
`define MERC_REC_MAX 7'h63
`define MERC_SEQ_LAST 8'hff
`define MERC_SEQ_FIRST 8'h01

// Clock field limits.
`define MERC_YEAR_MAX 16'h0063
`define MERC_MONTH_MAX 16'h000c
`define MERC_HOUR_MAX 16'h0017
`define MERC_MINSEC_MAX 16'h003b
`define MERC_HUND_MAX 16'h0063
`define MERC_FIELD_MIN 16'h0001
`define MERC_PRESET_ALL 7'h7f

// Timing: one clock_hundredths at the core clock.
`define MERC_CLK_PERIOD_NS 100
`define MERC_TICK_NS 10000000

`endif

// File: merc_event_bank.v
// Event record store, record window registers and real-time clock of the protection device.
`timescale 1ns/1ps
`include "merc_regs.vh"

module merc_event_bank #(
    parameter TICK_CYCLES = `MERC_TICK_NS / `MERC_CLK_PERIOD_NS
) (
    // Clock and reset.
    input wire MCLK,
    input wire RESET_N,
    // Register access port, one word per access.
    input wire [15:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire REG_TXN_END,
    output reg [15:0] REG_RDATA,
    output reg REG_RVALID,
    // Event source.
    input wire EVT_PUSH,
    input wire EVT_INFO,
    input wire [14:0] EVT_POINT,
    input wire [5:0] EVT_VALUE,
    // Status.
    output reg UNREAD_RECORD_FLAG
);

    // The divider compare is cut to the counter width on purpose; the count fits 17 bits.
    localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
    localparam [16:0] TICK_LAST = TICK_LAST_FULL[16:0];

    // Record storage and pointers.
    reg [95:0] mem [0:127];
    reg [6:0] wr_ptr;
    reg [6:0] count;
    reg [6:0] unread;
    reg [7:0] seq;
    reg [15:0] select;
    reg sel_pend;
    reg [6:0] sel_idx;
    reg [95:0] win;

    // Next values of the record control state.
    reg [6:0] next_wr_ptr;
    reg [6:0] next_count;
    reg [6:0] next_unread;
    reg [7:0] next_seq;
    reg next_sel_pend;
    reg [6:0] next_sel_idx;
    reg next_clear;
    reg [15:0] neg_n;

    // Running clock, preset shadow and tick divider.
    reg [6:0] rtc_year;
    reg [3:0] rtc_month;
    reg [4:0] rtc_day;
    reg [4:0] rtc_hour;
    reg [5:0] rtc_minute;
    reg [5:0] rtc_second;
    reg [6:0] rtc_hund;
    reg [15:0] shadow [0:6];
    reg [6:0] preset_mask;
    reg [16:0] tick_cnt;

    wire sel_wr = REG_WR && (REG_ADDR == `MERC_ADDR_SELECT);
    wire clk_wr = REG_WR && (REG_ADDR >= `MERC_ADDR_CLK_YEAR) &&
        (REG_ADDR <= `MERC_ADDR_CLK_HUNDREDTHS);
    wire [15:0] clk_off = REG_ADDR - `MERC_ADDR_CLK_YEAR;
    wire tick = (tick_cnt == TICK_LAST);

    // Days in a month; every fourth year is a leap year inside the two-digit century.
    function [4:0] month_days;
        input [3:0] month;
        input [6:0] year;
        begin
            case (month)
                4'h2: month_days = (year[1:0] == 2'b00) ? 5'h1d : 5'h1c;
                4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
                default: month_days = 5'h1f;
            endcase
        end
    endfunction

    // Record packed from the running clock; the clock keeps hundredths, so milliseconds
    // step by ten, which is the resolution the time stamp really has.
    wire [15:0] pk_year_month = {1'b0, rtc_year, 4'h0, rtc_month}; // see R5
    wire [15:0] pk_day_hour = {3'b000, rtc_day, 3'b000, rtc_hour}; // see R5
    wire [15:0] pk_min_sec = {2'b00, rtc_minute, 2'b00, rtc_second}; // see R6
    wire [15:0] pk_msec = {6'h00, rtc_hund, 3'b000} + {8'h00, rtc_hund, 1'b0}; // see R6
    wire [15:0] pk_type = {EVT_INFO, EVT_POINT}; // see R7 see R8
    wire [15:0] pk_value = EVT_INFO ? {10'h000, EVT_VALUE} // see R10
        : {15'h0000, EVT_VALUE[0]}; // see R9
    wire [95:0] pk_record = {pk_year_month, pk_day_hour, pk_min_sec, pk_msec, pk_type, pk_value};

    // Selection decode then event push, so a push in the same cycle is never lost.
    always @*
    begin
        next_wr_ptr = wr_ptr;
        next_count = count;
        next_unread = unread;
        next_seq = seq;
        next_sel_pend = 1'b0;
        next_sel_idx = sel_idx;
        next_clear = 1'b0;
        neg_n = ~REG_WDATA + 16'h0001;
        if (sel_wr)
        begin
            if (REG_WDATA == `MERC_SEL_OLDEST_UNREAD)
            begin
                if (unread != 7'h00)
                begin
                    next_sel_pend = 1'b1; // see R1
                    next_sel_idx = wr_ptr - unread;
                    next_unread = unread - 7'h01; // see R15
                    next_seq = (seq == `MERC_SEQ_LAST) ? `MERC_SEQ_FIRST : seq + 8'h01; // see R15
                end
            end
            else if (REG_WDATA == `MERC_SEL_OLDEST_STORED)
            begin
                if (count != 7'h00)
                begin
                    next_sel_pend = 1'b1; // see R1
                    next_sel_idx = wr_ptr - count;
                    if (unread == count)
                    begin
                        next_unread = unread - 7'h01; // see R15
                        next_seq = (seq == `MERC_SEQ_LAST) ? `MERC_SEQ_FIRST : seq + 8'h01;
                    end
                end
            end
            else if (REG_WDATA == `MERC_SEL_CLEAR)
            begin
                next_clear = 1'b1; // see R2
                next_count = 7'h00;
                next_unread = 7'h00;
            end
            else if (REG_WDATA[15] && (neg_n <= {9'h000, count}) && (neg_n != 16'h0000))
            begin
                next_sel_pend = 1'b1; // see R3
                next_sel_idx = wr_ptr - neg_n[6:0];
                if (neg_n[6:0] == unread)
                begin
                    next_unread = unread - 7'h01; // see R15
                    next_seq = (seq == `MERC_SEQ_LAST) ? `MERC_SEQ_FIRST : seq + 8'h01;
                end
            end
        end
        if (EVT_PUSH)
        begin
            next_wr_ptr = wr_ptr + 7'h01;
            if (next_count != `MERC_REC_MAX)
            begin
                next_count = next_count + 7'h01;
            end
            if (next_unread != `MERC_REC_MAX)
            begin
                next_unread = next_unread + 7'h01;
            end
        end
    end

    // Record control registers.
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_ptr <= 7'h00;
            count <= 7'h00;
            unread <= 7'h00;
            seq <= 8'h00;
            select <= 16'h0000;
            sel_pend <= 1'b0;
            sel_idx <= 7'h00;
            win <= {96{1'b0}};
            UNREAD_RECORD_FLAG <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            count <= next_count;
            unread <= next_unread;
            seq <= next_seq;
            sel_pend <= next_sel_pend;
            sel_idx <= next_sel_idx;
            UNREAD_RECORD_FLAG <= (next_unread != 7'h00); // see R14
            if (sel_wr)
            begin
                select <= REG_WDATA; // see R4
            end
            // The window follows the store one cycle late, after the index settles.
            if (next_clear)
            begin
                win <= {96{1'b0}}; // see R2
            end
            else if (sel_pend)
            begin
                win <= mem[sel_idx];
            end
        end
    end

    // Record array; the array itself needs no reset since pointers guard every read.
    always @(posedge MCLK)
    begin
        if (EVT_PUSH)
        begin
            mem[wr_ptr] <= pk_record;
        end
    end

    // Preset shadow; the clock loads only when a transaction has written all seven words.
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_shadow
            always @(posedge MCLK or negedge RESET_N)
            begin
                if (!RESET_N)
                begin
                    shadow[gi] <= 16'h0000;
                    preset_mask[gi] <= 1'b0;
                end
                else
                begin
                    if (clk_wr && (clk_off[2:0] == gi))
                    begin
                        shadow[gi] <= REG_WDATA;
                    end
                    if (REG_TXN_END)
                    begin
                        preset_mask[gi] <= 1'b0;
                    end
                    else if (clk_wr && (clk_off[2:0] == gi))
                    begin
                        preset_mask[gi] <= 1'b1; // see R12
                    end
                end
            end
        end
    endgenerate

    // A preset with any field out of range is refused whole.
    wire preset_ok = (shadow[0] <= `MERC_YEAR_MAX) &&
        (shadow[1] >= `MERC_FIELD_MIN) && (shadow[1] <= `MERC_MONTH_MAX) &&
        (shadow[2] >= `MERC_FIELD_MIN) &&
        (shadow[2] <= {11'h000, month_days(shadow[1][3:0], shadow[0][6:0])}) &&
        (shadow[3] <= `MERC_HOUR_MAX) && (shadow[4] <= `MERC_MINSEC_MAX) &&
        (shadow[5] <= `MERC_MINSEC_MAX) && (shadow[6] <= `MERC_HUND_MAX); // see R13
    wire preset_go = REG_TXN_END && (preset_mask == `MERC_PRESET_ALL) && preset_ok; // see R12

    // Top-of-range flags for the carry chain, taken from the shared field limits.
    wire hund_top = ({9'h000, rtc_hund} == `MERC_HUND_MAX);
    wire sec_top = ({10'h000, rtc_second} == `MERC_MINSEC_MAX);
    wire min_top = ({10'h000, rtc_minute} == `MERC_MINSEC_MAX);
    wire hour_top = ({11'h000, rtc_hour} == `MERC_HOUR_MAX);
    wire month_top = ({12'h000, rtc_month} == `MERC_MONTH_MAX);
    wire year_top = ({9'h000, rtc_year} == `MERC_YEAR_MAX);

    // Running clock with carries from hundredths up to year.
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tick_cnt <= 17'h0_0000;
            rtc_year <= 7'h00;
            rtc_month <= 4'h1;
            rtc_day <= 5'h01;
            rtc_hour <= 5'h00;
            rtc_minute <= 6'h00;
            rtc_second <= 6'h00;
            rtc_hund <= 7'h00;
        end
        else if (preset_go)
        begin
            tick_cnt <= 17'h0_0000;
            rtc_year <= shadow[0][6:0];
            rtc_month <= shadow[1][3:0];
            rtc_day <= shadow[2][4:0];
            rtc_hour <= shadow[3][4:0];
            rtc_minute <= shadow[4][5:0];
            rtc_second <= shadow[5][5:0];
            rtc_hund <= shadow[6][6:0];
        end
        else
        begin
            tick_cnt <= tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
            if (tick)
            begin
                rtc_hund <= hund_top ? 7'h00 : rtc_hund + 7'h01; // see R13
                if (hund_top)
                begin
                    rtc_second <= sec_top ? 6'h00 : rtc_second + 6'h01;
                    if (sec_top)
                    begin
                        rtc_minute <= min_top ? 6'h00 : rtc_minute + 6'h01;
                        if (min_top)
                        begin
                            rtc_hour <= hour_top ? 5'h00 : rtc_hour + 5'h01;
                            if (hour_top)
                            begin
                                if (rtc_day == month_days(rtc_month, rtc_year))
                                begin
                                    rtc_day <= 5'h01;
                                    rtc_month <= month_top ? 4'h1 : rtc_month + 4'h1;
                                    if (month_top)
                                    begin
                                        rtc_year <= year_top ? 7'h00 : rtc_year + 7'h01;
                                    end
                                end
                                else
                                begin
                                    rtc_day <= rtc_day + 5'h01;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // Read port; unmapped addresses answer zero, answer one cycle after the strobe.
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                case (REG_ADDR)
                    `MERC_ADDR_SELECT: REG_RDATA <= select; // see R4
                    `MERC_ADDR_SEQUENCE: REG_RDATA <= {8'h00, seq};
                    `MERC_ADDR_UNREAD: REG_RDATA <= {9'h000, unread};
                    `MERC_ADDR_YEAR_MONTH: REG_RDATA <= win[95:80];
                    `MERC_ADDR_DAY_HOUR: REG_RDATA <= win[79:64];
                    `MERC_ADDR_MIN_SEC: REG_RDATA <= win[63:48];
                    `MERC_ADDR_MSEC: REG_RDATA <= win[47:32];
                    `MERC_ADDR_TYPE: REG_RDATA <= win[31:16];
                    `MERC_ADDR_VALUE: REG_RDATA <= win[15:0];
                    `MERC_ADDR_CLK_YEAR: REG_RDATA <= {9'h000, rtc_year}; // see R11
                    `MERC_ADDR_CLK_MONTH: REG_RDATA <= {12'h000, rtc_month};
                    `MERC_ADDR_CLK_DAY: REG_RDATA <= {11'h000, rtc_day};
                    `MERC_ADDR_CLK_HOUR: REG_RDATA <= {11'h000, rtc_hour};
                    `MERC_ADDR_CLK_MINUTE: REG_RDATA <= {10'h000, rtc_minute};
                    `MERC_ADDR_CLK_SECOND: REG_RDATA <= {10'h000, rtc_second};
                    `MERC_ADDR_CLK_HUNDREDTHS: REG_RDATA <= {9'h000, rtc_hund};
                    default: REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

endmodule // merc_event_bank

// File: merc_props.sv
// Checker of the event bank register port and status flag.
`timescale 1ns/1ps
module merc_props (
    // Clock and reset.
    input wire MCLK,
    input wire RESET_N,
    // Register port and status.
    input wire [15:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire REG_TXN_END,
    input wire [15:0] REG_RDATA,
    input wire REG_RVALID,
    input wire EVT_PUSH,
    input wire UNREAD_RECORD_FLAG
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // A selection write; the flag may lag it by one cycle.
    wire sel_wr = REG_WR && REG_ADDR == 16'h029f;
    wire flag = UNREAD_RECORD_FLAG;
    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered next cycle");
    a_no_stray_valid: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("answer without a read");
    a_rdata_holds: assert property (!REG_RVALID |-> $stable(REG_RDATA))
        else $error("read data moved between reads");
    a_push_flags: assert property (EVT_PUSH |=> flag)
        else $error("flag low after a stored event");
    a_flag_cause: assert property ($rose(flag) |-> $past(EVT_PUSH))
        else $error("flag rose without an event");
    a_flag_drop: assert property ($fell(flag) |-> $past(sel_wr) || $past(sel_wr, 2))
        else $error("flag fell without a selection");
    a_clear_empties: assert property (sel_wr && REG_WDATA == 16'h0003 && !EVT_PUSH
        |-> ##[1:2] !flag)
        else $error("clear left records unread");
    a_count_flag: assert property (REG_RD && REG_ADDR == 16'h02a1
        |=> (REG_RDATA != 16'h0000) == $past(flag))
        else $error("unread count and flag disagree");
    a_month_range: assert property (REG_RD && REG_ADDR == 16'h02d2
        |=> REG_RDATA inside {[1:12]})
        else $error("clock month out of range");
    a_msec_range: assert property (REG_RD && REG_ADDR == 16'h02a5
        |=> REG_RDATA <= 16'h03e7)
        else $error("milliseconds out of range");
    a_value_range: assert property (REG_RD && REG_ADDR == 16'h02a7
        |=> REG_RDATA <= 16'h003f)
        else $error("event value out of range");
    c_preset: cover property (REG_TXN_END);
    c_select: cover property (sel_wr && REG_WDATA == 16'h0001);
    c_drained: cover property ($fell(flag));
endmodule // merc_props

// File: merc_master.sv
// Register master model driving the event bank access port.
`timescale 1ns/1ps
module merc_master (
    // Clock.
    input wire MCLK,
    // Access port.
    output logic [15:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    output logic REG_TXN_END,
    input wire [15:0] REG_RDATA,
    input wire REG_RVALID
);
    // Idle port at start.
    initial
    begin
        {REG_ADDR, REG_WDATA, REG_WR, REG_RD, REG_TXN_END} = 35'h0;
    end
    // One word written; address and data are inverted after so stale values never pass.
    task automatic wr(input [15:0] a, input [15:0] d);
        begin
            {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
            @(posedge MCLK);
            #1;
            {REG_ADDR, REG_WDATA, REG_WR} = {~a, ~d, 1'b0};
            @(posedge MCLK);
            #1;
        end
    endtask
    // One word read; err is set when the answer is missing in the following cycle.
    task automatic rd(input [15:0] a, output [15:0] d, output err);
        begin
            {REG_ADDR, REG_RD} = {a, 1'b1};
            @(posedge MCLK);
            #1;
            {REG_ADDR, REG_RD} = {~a, 1'b0};
            err = (REG_RVALID !== 1'b1);
            d = REG_RDATA;
            @(posedge MCLK);
            #1;
        end
    endtask
    // Clock preset of n words from year on, closed by the transaction boundary.
    task automatic preset(input [111:0] v, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
                wr(16'h02d1 + i[15:0], v[16*i +: 16]);
            REG_TXN_END = 1'b1;
            @(posedge MCLK);
            #1;
            REG_TXN_END = 1'b0;
        end
    endtask
endmodule // merc_master

// File: merc_event_bank_bench.sv
// Self-checking bench for the event record bank and its clock.
`timescale 1ns/1ps
module merc_event_bank_bench;
    localparam integer TICK = 2000;
    reg MCLK, RESET_N, EVT_PUSH, EVT_INFO, e;
    reg [14:0] EVT_POINT;
    reg [5:0] EVT_VALUE;
    wire [15:0] REG_ADDR, REG_WDATA, REG_RDATA;
    wire REG_WR, REG_RD, REG_TXN_END, REG_RVALID, UNREAD_RECORD_FLAG;
    integer fails, tests_run, i, n, k;
    reg [15:0] d, typ [0:7], val [0:7];
    reg [111:0] p;
    merc_event_bank #(.TICK_CYCLES(TICK)) DUT (.MCLK, .RESET_N, .REG_ADDR, .REG_WDATA,
        .REG_WR, .REG_RD, .REG_TXN_END, .REG_RDATA, .REG_RVALID, .EVT_PUSH, .EVT_INFO,
        .EVT_POINT, .EVT_VALUE, .UNREAD_RECORD_FLAG);
    merc_master m (.MCLK, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_TXN_END,
        .REG_RDATA, .REG_RVALID);
    // Free-running 10 MHz clock.
    initial
    begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // Verdict and end of run.
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // One comparison.
    task chk(input [15:0] g, input [15:0] x);
        begin
            tests_run = tests_run + 1;
            if (g !== x)
            begin
                fails = fails + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    // Read and compare; a missing answer ends the run.
    task rc(input [15:0] a, input [15:0] x);
        begin
            m.rd(a, d, e);
            if (e)
            begin
                fails = fails + 1;
                $display("[FAIL] t=%0t no answer at %h exp %h", $time, a, x);
                end_of_test;
            end
            else
                chk(d, x);
        end
    endtask
    // Packed stamp words from the clock image p.
    function [15:0] stamp(input integer w);
        case (w)
            0: stamp = {p[7:0], p[23:16]};
            1: stamp = {p[39:32], p[55:48]};
            2: stamp = {p[71:64], p[87:80]};
            default: stamp = p[111:96] * 10;
        endcase
    endfunction
    // All seven clock registers against p.
    task clk_chk;
        for (k = 0; k < 7; k = k + 1) rc(16'h02d1 + k[15:0], p[16*k +: 16]);
    endtask
    // Window against stored record r.
    task rec_chk(input integer r);
        integer w;
        begin
            for (w = 0; w < 4; w = w + 1) rc(16'h02a2 + w[15:0], stamp(w));
            rc(16'h02a6, typ[r]);
            rc(16'h02a7, val[r]);
        end
    endtask
    // Random legal time; hundredths stay low so no carry lands during a test.
    task rnd_clock;
        p = {16'($urandom % 50), 16'($urandom % 60), 16'($urandom % 60), 16'($urandom % 24),
            16'($urandom % 28 + 1), 16'($urandom % 12 + 1), 16'($urandom % 100)};
    endtask
    // One event pulse.
    task push(input inf, input [14:0] pt, input [5:0] v);
        begin
            {EVT_INFO, EVT_POINT, EVT_VALUE, EVT_PUSH} = {inf, pt, v, 1'b1};
            @(posedge MCLK);
            #1;
            EVT_PUSH = 1'b0;
            @(posedge MCLK);
            #1;
        end
    endtask
    // Main sequence.
    initial
    begin
        {fails, tests_run} = 64'h0;
        {RESET_N, EVT_PUSH, EVT_INFO, EVT_POINT, EVT_VALUE} = 24'h0;
        void'($urandom(56));
        repeat (8) @(posedge MCLK);
        #1;
        RESET_N = 1'b1;
        p = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
        clk_chk;
        rc(16'h029f, 16'h0000);
        rc(16'h0300, 16'h0000);
        $display("test reset done");
        rnd_clock;
        m.preset(p, 7);
        clk_chk;
        m.preset({p[111:16], p[15:0] ^ 16'h0001}, 6);
        clk_chk;
        m.preset({p[111:32], 16'h000d, p[15:0] ^ 16'h0001}, 7);
        clk_chk;
        m.preset({p[111:48], 16'h001e, 16'h0002, p[15:0]}, 7);
        clk_chk;
        p = {16'h0063, 16'h003b, 16'h003b, 16'h0017, 16'h001f, 16'h000c, 16'h0063};
        m.preset(p, 7);
        repeat (TICK) @(posedge MCLK);
        #1;
        p = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
        clk_chk;
        $display("test clock done");
        rnd_clock;
        m.preset(p, 7);
        n = 3 + $urandom % 4;
        for (i = 0; i < n; i = i + 1)
        begin
            typ[i] = 16'($urandom);
            if (i < 2) typ[i][15] = i[0];
            val[i] = 16'($urandom % 64);
            push(typ[i][15], typ[i][14:0], val[i][5:0]);
            if (!typ[i][15]) val[i] = {15'h0, val[i][0]};
        end
        rc(16'h02a1, n[15:0]);
        chk({15'h0, UNREAD_RECORD_FLAG}, 16'h0001);
        for (i = 0; i < n; i = i + 1)
        begin
            m.wr(16'h029f, 16'h0001);
            rec_chk(i);
            rc(16'h02a0, i[15:0] + 16'h0001);
            rc(16'h02a1, n[15:0] - i[15:0] - 16'h0001);
        end
        chk({15'h0, UNREAD_RECORD_FLAG}, 16'h0000);
        m.wr(16'h029f, 16'h0002);
        rec_chk(0);
        k = 1 + $urandom % n;
        i = n - k;
        m.wr(16'h029f, 16'(-k));
        rec_chk(i);
        rc(16'h029f, 16'(-k));
        m.wr(16'h02a6, ~typ[i]);
        rc(16'h02a6, typ[i]);
        $display("test records done");
        push(1'b1, 15'h0005, 6'h05);
        m.wr(16'h029f, 16'h0003);
        rc(16'h02a1, 16'h0000);
        rc(16'h02a6, 16'h0000);
        chk({15'h0, UNREAD_RECORD_FLAG}, 16'h0000);
        $display("test clear done");
        for (i = n + 1; i <= 256; i = i + 1)
        begin
            push(1'b0, 15'h0001, 6'h01);
            m.wr(16'h029f, 16'h0001);
        end
        rc(16'h02a0, 16'h0001);
        for (i = 0; i < 100; i = i + 1) push(1'b1, 15'h7fff, 6'h3f);
        rc(16'h02a1, 16'h0063);
        m.wr(16'h029f, 16'h0001);
        rc(16'h02a6, 16'hffff);
        rc(16'h02a7, 16'h003f);
        $display("test wrap done");
        end_of_test;
    end
endmodule // merc_event_bank_bench
bind merc_event_bank merc_props chk (.MCLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_TXN_END, .REG_RDATA, .REG_RVALID, .EVT_PUSH, .UNREAD_RECORD_FLAG);
